// ### hbsw_host_mem.sv
// hbsw_host_mem: shared host memory taking status word writes.
// assumes wb_valid holds its word until a cycle with wb_ready high.
module hbsw_host_mem
  import hbsw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic wb_valid,
  input hbsw_pkg::hbsw_wb_req_s wb_req,
  output logic wb_ready,
  output logic [31:0] last_addr,
  output logic [31:0] last_data,
  output int writes
);
  import hbsw_pkg::*;
  logic [1:0] ph_reg; // stall phase in slow mode
  // accept writes, every fourth cycle only when slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_reg <= 2'h0;
      wb_ready <= 1'b0;
      last_addr <= 32'h0000_0000;
      last_data <= 32'h0000_0000;
      writes <= 0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      // no ready right after a taken word: avoids a stale accept
      wb_ready <= wb_valid && !wb_ready && (!slow || ph_reg == 2'h3);
      if (wb_valid && wb_ready) begin
        last_addr <= wb_req.addr;
        last_data <= wb_req.data;
        writes <= writes + 1;
      end
    end
  end
endmodule : hbsw_host_mem

// ### hbsw_pkg.sv
// hbsw_pkg: constants, status word layouts and states shared by the
// buffer status writeback block.
// assumes a 32-bit descriptor word format and a single pclk domain.
package hbsw_pkg;

  // apb register byte offsets
  localparam logic [7:0] HBSW_CTRL_OFS = 8'h00;  // inhibit bits
  localparam logic [7:0] HBSW_LIMIT_OFS = 8'h04; // max message octets
  localparam logic [7:0] HBSW_RXSTAT_OFS = 8'h08; // last rx status word
  localparam logic [7:0] HBSW_TXSTAT_OFS = 8'h0c; // live tx status word
  localparam int HBSW_ADDR_W = 8;

  // control register field positions
  localparam int HBSW_TX_INH_BIT = 0;
  localparam int HBSW_RX_INH_BIT = 1;

  // values after reset
  localparam logic [1:0] HBSW_CTRL_RST = 2'h0;
  localparam logic [13:0] HBSW_LIMIT_RST = 14'h0000; // zero: no check

  // receive fault codes
  localparam logic [3:0] HBSW_ERR_NONE = 4'h0;
  localparam logic [3:0] HBSW_ERR_OVERFLOW = 4'h1;
  localparam logic [3:0] HBSW_ERR_ALIGN_CHG = 4'h2;
  localparam logic [3:0] HBSW_ERR_OOF = 4'h8;
  localparam logic [3:0] HBSW_ERR_CHECK = 4'h9;
  localparam logic [3:0] HBSW_ERR_OCTET = 4'ha;
  localparam logic [3:0] HBSW_ERR_ABORT = 4'hb;
  localparam logic [3:0] HBSW_ERR_OVERSIZE = 4'hc;

  // ownership values per direction
  localparam logic HBSW_TX_OWN_HOST = 1'b0;
  localparam logic HBSW_TX_OWN_DEV = 1'b1;
  localparam logic HBSW_RX_OWN_HOST = 1'b1;

  // frame flywheel length in bit ticks
  localparam logic [8:0] HBSW_FRAME_BITS = 9'h0c1;

  // transmit status word
  typedef struct packed {
    logic owner;          // bit 31
    logic rsvd30;
    logic end_of_message_flag;            // bit 29
    logic [14:0] rsvd28;  // bits 28:14
    logic [13:0] len;     // bits 13:0
  } hbsw_tx_stat_s;

  // receive status word
  typedef struct packed {
    logic owner;          // bit 31
    logic rsvd30;
    logic end_of_message_flag;            // bit 29
    logic [8:0] rsvd28;   // bits 28:20
    logic [3:0] err;      // bits 19:16
    logic [1:0] rsvd15;   // bits 15:14
    logic [13:0] len;     // bits 13:0
  } hbsw_rx_stat_s;

  // one memory write toward shared host memory
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } hbsw_wb_req_s;

  // writeback sequencer states
  typedef enum logic [2:0] {
    HBSW_WB_IDLE = 3'b001,
    HBSW_WB_TX = 3'b010,
    HBSW_WB_RX = 3'b100
  } hbsw_wb_state_e;

endpackage : hbsw_pkg

// ### hbsw_top.sv
// hbsw_top: buffer status word builder and writeback for one tx and
// one rx hdlc channel, plus descriptor pointer forming and apb config.
// assumes framing logic on pclk supplies octet and end events, a bus
// master drains wb_req, and descriptor fetch supplies the pointers.
//
// How it works
// [RL1] tx owner bit 31 zero when done
// [RL2] rx owner bit 31 one returns buffer
// [RL3] tx eom copied from descriptor
// [RL4] tx length is octets actually sent
// [RL5] rx eom only on message last octet
// [RL6] rx fault code in bits 19:16
// [RL7] code 1 on receive fifo overflow
// [RL8] code 2 on misaligned frame sync
// [RL9] code 8 while out of frame
// [RL10] code 9 on check sequence mismatch
// [RL11] code 10 beats check mismatch
// [RL12] code 11 on abort termination
// [RL13] code 12 oversize, discard, hunt flags
// [RL14] next address gets two zero bits
// [RL15] host loops list to first descriptor
// [RL16] data pointer is any byte address
// [RL17] status word overwrites serviced descriptor
// [RL18] inhibit bit suppresses status write
// [RL19] rx length is octets stored
// [RL20] reserved status bits written zero
module hbsw_top
  import hbsw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [hbsw_pkg::HBSW_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_active,
  input wire logic tx_done,
  input wire logic tx_eom,
  input wire logic [13:0] tx_octets_sent,
  input wire logic [31:0] tx_desc_addr,
  output logic tx_busy,
  output logic tx_returned,
  input wire logic [31:0] rx_desc_addr,
  input wire logic [13:0] rx_buf_len,
  input wire logic [31:0] data_buffer_pointer,
  input wire logic rx_octet_valid,
  input wire logic rx_flag_end,
  input wire logic rx_abort_end,
  input wire logic rx_fcs_bad,
  input wire logic [2:0] rx_residue_bits,
  input wire logic rx_fifo_overflow,
  input wire logic bit_tick,
  input wire logic receive_frame_sync,
  input wire logic out_of_frame_input,
  output logic rx_busy,
  output logic rx_returned,
  output logic rx_octet_write,
  output logic [31:0] rx_octet_addr,
  output logic [3:0] rx_octet_strb,
  output logic rx_discard,
  output logic rx_hunt,
  input wire logic [31:0] next_descriptor_pointer,
  input wire logic next_ptr_valid,
  output logic [31:0] next_desc_addr,
  output logic next_desc_valid,
  output logic wb_valid,
  output hbsw_pkg::hbsw_wb_req_s wb_req,
  input wire logic wb_ready
);
  import hbsw_pkg::*;

  // apb registers
  logic [1:0] ctrl_reg, ctrl_next;       // inhibit bits
  logic [13:0] limit_reg, limit_next;    // oversize limit
  logic [31:0] prdata_reg, prdata_next;  // read data
  logic pslverr_reg, pslverr_next;       // unmapped flag
  logic apb_wr, apb_rd, apb_hit;         // decoded access

  // pin synchronisers; stage one feeds stage two only
  logic sync_a_reg, sync_b_reg, sync_c_reg;
  logic oof_a_reg, oof_b_reg, oof_c_reg;

  // flywheel
  logic [8:0] fly_reg, fly_next;
  logic frame_alignment_change_evt, oof_evt;

  // receive buffer tracking
  logic [13:0] rx_cnt_reg, rx_cnt_next;   // octets in this buffer
  logic [13:0] msg_len_reg, msg_len_next; // octets in this message
  logic discard_reg, discard_next;        // oversize drop state
  logic hunt_reg, hunt_next;
  logic oct_wr_reg, oct_wr_next;
  logic [31:0] oct_addr_reg, oct_addr_next;
  logic [3:0] oct_strb_reg, oct_strb_next;
  hbsw_rx_stat_s rx_last_reg, rx_last_next; // last closed word
  logic rx_pend_reg, rx_pend_next;
  logic [31:0] rx_waddr_reg, rx_waddr_next;
  logic rx_ret_reg, rx_ret_next;

  // transmit tracking
  hbsw_tx_stat_s tx_word_reg, tx_word_next; // live tx status word
  logic tx_pend_reg, tx_pend_next;
  logic [31:0] tx_waddr_reg, tx_waddr_next;
  logic tx_ret_reg, tx_ret_next;

  // writeback sequencer
  hbsw_wb_state_e wb_state_reg, wb_state_next;
  hbsw_wb_req_s wb_req_reg, wb_req_next;

  // descriptor pointer output
  logic [31:0] nda_reg, nda_next;
  logic ndv_reg, ndv_next;

  // combinational helpers for receive closing
  logic oct_take, over_evt, full_evt, msg_end, close_buf;
  logic [13:0] cnt_inc, msg_inc;
  logic [31:0] byte_addr;
  logic [3:0] err_code;
  hbsw_rx_stat_s rx_word;

  // apb decode: zero wait states, so pready is constant high
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~penable & ~pwrite;
  assign apb_hit = (paddr == HBSW_CTRL_OFS) | (paddr == HBSW_LIMIT_OFS) |
                   (paddr == HBSW_RXSTAT_OFS) | (paddr == HBSW_TXSTAT_OFS);

  // register next values; read data captured in setup phase
  always_comb begin
    ctrl_next = ctrl_reg;
    limit_next = limit_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (apb_wr) begin
      // unmapped writes fall through every decode
      if (paddr == HBSW_CTRL_OFS) begin
        ctrl_next = pwdata[1:0];
      end
      if (paddr == HBSW_LIMIT_OFS) begin
        limit_next = pwdata[13:0];
      end
    end
    if (psel & ~penable) begin
      // setup phase: load read data, flag unmapped access
      prdata_next = 32'h0000_0000;
      pslverr_next = ~apb_hit;
      if (apb_rd) begin
        case (paddr)
          HBSW_CTRL_OFS: prdata_next = {30'h0000_0000, ctrl_reg};
          HBSW_LIMIT_OFS: prdata_next = {18'h0_0000, limit_reg};
          HBSW_RXSTAT_OFS: prdata_next = rx_last_reg;
          HBSW_TXSTAT_OFS: prdata_next = tx_word_reg;
          default: prdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  // apb registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= HBSW_CTRL_RST;
      limit_reg <= HBSW_LIMIT_RST;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      limit_reg <= limit_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready = 1'b1;
  assign prdata = prdata_reg;
  // error only shows in the access phase
  assign pslverr = pslverr_reg & psel & penable;

  // two-flop synchronisers, third flop for edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_reg <= 1'b0;
      sync_b_reg <= 1'b0;
      sync_c_reg <= 1'b0;
      oof_a_reg <= 1'b0;
      oof_b_reg <= 1'b0;
      oof_c_reg <= 1'b0;
    end else begin
      sync_a_reg <= receive_frame_sync;
      sync_b_reg <= sync_a_reg;
      sync_c_reg <= sync_b_reg;
      oof_a_reg <= out_of_frame_input;
      oof_b_reg <= oof_a_reg;
      oof_c_reg <= oof_b_reg;
    end
  end

  // [RL8] sync edge off flywheel zero
  assign frame_alignment_change_evt = sync_b_reg & ~sync_c_reg & (fly_reg != 9'h000);
  // [RL9] out of frame entry closes buffer
  assign oof_evt = oof_b_reg & ~oof_c_reg;

  // flywheel: sync edge realigns, ticks wrap at frame length
  always_comb begin
    fly_next = fly_reg;
    if (sync_b_reg & ~sync_c_reg) begin
      fly_next = 9'h000;
    end else if (bit_tick) begin
      fly_next = (fly_reg == HBSW_FRAME_BITS - 9'h001) ? 9'h000 :
                 fly_reg + 9'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fly_reg <= 9'h000;
    end else begin
      fly_reg <= fly_next;
    end
  end

  // receive octet bookkeeping helpers
  assign oct_take = rx_octet_valid & ~discard_reg;
  assign cnt_inc = rx_cnt_reg + 14'h0001;
  assign msg_inc = msg_len_reg + 14'h0001;
  // [RL13] octet beyond limit is oversize
  assign over_evt = oct_take & (limit_reg != 14'h0000) & (msg_inc > limit_reg);
  assign full_evt = oct_take & ~over_evt & (cnt_inc == rx_buf_len);
  // [RL16] byte address from any alignment
  assign byte_addr = data_buffer_pointer + {18'h0_0000, rx_cnt_reg};

  // fault code by priority; error events end the message
  always_comb begin
    err_code = HBSW_ERR_NONE;
    if (rx_fifo_overflow) begin
      // [RL7] overflow means data lost
      err_code = HBSW_ERR_OVERFLOW;
    end else if (frame_alignment_change_evt) begin
      err_code = HBSW_ERR_ALIGN_CHG;
    end else if (oof_b_reg) begin
      // [RL9] code while out of frame held
      err_code = HBSW_ERR_OOF;
    end else if (over_evt) begin
      err_code = HBSW_ERR_OVERSIZE;
    end else if (rx_abort_end & ~discard_reg) begin
      // [RL12] abort instead of closing flag
      err_code = HBSW_ERR_ABORT;
    end else if (rx_flag_end & ~discard_reg & (rx_residue_bits != 3'h0)) begin
      // [RL11] octet fault ahead of check
      err_code = HBSW_ERR_OCTET;
    end else if (rx_flag_end & ~discard_reg & rx_fcs_bad) begin
      // [RL10] closing flag, check mismatch
      err_code = HBSW_ERR_CHECK;
    end
  end

  // [RL5] message ends on flag or error termination
  assign msg_end = (err_code != HBSW_ERR_NONE) & (err_code != HBSW_ERR_OOF) |
                   oof_evt | ((rx_flag_end | rx_abort_end) & ~discard_reg);
  assign close_buf = msg_end | full_evt;

  // receive status word; reserved fields forced to zero
  always_comb begin
    rx_word = '0;
    // [RL2] owner one hands buffer back
    rx_word.owner = HBSW_RX_OWN_HOST;
    rx_word.end_of_message_flag = msg_end;
    // [RL6] fault code field
    rx_word.err = err_code;
    // [RL19] octets stored, last one included
    rx_word.len = (oct_take & ~over_evt) ? cnt_inc : rx_cnt_reg;
  end

  // receive state next values
  always_comb begin
    rx_cnt_next = rx_cnt_reg;
    msg_len_next = msg_len_reg;
    discard_next = discard_reg;
    hunt_next = 1'b0;
    oct_wr_next = 1'b0;
    oct_addr_next = oct_addr_reg;
    oct_strb_next = oct_strb_reg;
    rx_last_next = rx_last_reg;
    rx_pend_next = rx_pend_reg;
    rx_waddr_next = rx_waddr_reg;
    rx_ret_next = 1'b0;
    if (oct_take & ~over_evt) begin
      // [RL16] dword address plus byte lane
      oct_wr_next = 1'b1;
      oct_addr_next = {byte_addr[31:2], 2'b00};
      oct_strb_next = 4'h1 << byte_addr[1:0];
      rx_cnt_next = cnt_inc;
      msg_len_next = msg_inc;
    end
    if (over_evt) begin
      // [RL13] stop storing, go back to hunting
      discard_next = 1'b1;
      hunt_next = 1'b1;
    end else if (discard_reg & (rx_flag_end | rx_abort_end)) begin
      discard_next = 1'b0;
    end
    if (msg_end) begin
      msg_len_next = 14'h0000;
    end
    if (close_buf) begin
      rx_cnt_next = 14'h0000;
      rx_last_next = rx_word;
      rx_ret_next = 1'b1;
      // [RL18] inhibit bit skips status write
      if (!ctrl_reg[HBSW_RX_INH_BIT]) begin
        // [RL17] write over serviced descriptor
        rx_pend_next = 1'b1;
        rx_waddr_next = rx_desc_addr;
      end
    end
    if (wb_state_reg == HBSW_WB_RX && wb_ready) begin
      rx_pend_next = close_buf & ~ctrl_reg[HBSW_RX_INH_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt_reg <= 14'h0000;
      msg_len_reg <= 14'h0000;
      discard_reg <= 1'b0;
      hunt_reg <= 1'b0;
      oct_wr_reg <= 1'b0;
      oct_addr_reg <= 32'h0000_0000;
      oct_strb_reg <= 4'h0;
      rx_last_reg <= '0;
      rx_pend_reg <= 1'b0;
      rx_waddr_reg <= 32'h0000_0000;
      rx_ret_reg <= 1'b0;
    end else begin
      rx_cnt_reg <= rx_cnt_next;
      msg_len_reg <= msg_len_next;
      discard_reg <= discard_next;
      hunt_reg <= hunt_next;
      oct_wr_reg <= oct_wr_next;
      oct_addr_reg <= oct_addr_next;
      oct_strb_reg <= oct_strb_next;
      rx_last_reg <= rx_last_next;
      rx_pend_reg <= rx_pend_next;
      rx_waddr_reg <= rx_waddr_next;
      rx_ret_reg <= rx_ret_next;
    end
  end

  // transmit status word; live copy shows device ownership
  always_comb begin
    tx_word_next = tx_word_reg;
    tx_pend_next = tx_pend_reg;
    tx_waddr_next = tx_waddr_reg;
    tx_ret_next = 1'b0;
    if (tx_active) begin
      // [RL1] owner one while buffer in use
      tx_word_next.owner = HBSW_TX_OWN_DEV;
    end
    if (tx_done) begin
      tx_word_next = '0;
      // [RL1] owner zero hands buffer back
      tx_word_next.owner = HBSW_TX_OWN_HOST;
      // [RL3] eom copied from descriptor
      tx_word_next.end_of_message_flag = tx_eom;
      // [RL4] octets actually sent
      tx_word_next.len = tx_octets_sent;
      tx_ret_next = 1'b1;
      // [RL18] inhibit bit skips status write
      if (!ctrl_reg[HBSW_TX_INH_BIT]) begin
        tx_pend_next = 1'b1;
        tx_waddr_next = tx_desc_addr;
      end
    end
    if (wb_state_reg == HBSW_WB_TX && wb_ready) begin
      tx_pend_next = tx_done & ~ctrl_reg[HBSW_TX_INH_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_word_reg <= '0;
      tx_pend_reg <= 1'b0;
      tx_waddr_reg <= 32'h0000_0000;
      tx_ret_reg <= 1'b0;
    end else begin
      tx_word_reg <= tx_word_next;
      tx_pend_reg <= tx_pend_next;
      tx_waddr_reg <= tx_waddr_next;
      tx_ret_reg <= tx_ret_next;
    end
  end

  // writeback sequencer: tx first, then rx, one word at a time
  always_comb begin
    wb_state_next = wb_state_reg;
    wb_req_next = wb_req_reg;
    case (wb_state_reg)
      HBSW_WB_IDLE: begin
        if (tx_pend_reg) begin
          // [RL20] reserved bits already zero in word
          wb_state_next = HBSW_WB_TX;
          wb_req_next.addr = tx_waddr_reg;
          wb_req_next.data = tx_word_reg;
        end else if (rx_pend_reg) begin
          wb_state_next = HBSW_WB_RX;
          wb_req_next.addr = rx_waddr_reg;
          wb_req_next.data = rx_last_reg;
        end
      end
      HBSW_WB_TX, HBSW_WB_RX: begin
        // hold the request until the master takes it
        if (wb_ready) begin
          wb_state_next = HBSW_WB_IDLE;
        end
      end
      default: wb_state_next = HBSW_WB_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_state_reg <= HBSW_WB_IDLE;
      wb_req_reg <= '0;
    end else begin
      wb_state_reg <= wb_state_next;
      wb_req_reg <= wb_req_next;
    end
  end

  // [RL14] next descriptor address, dword aligned
  always_comb begin
    nda_next = nda_reg;
    ndv_next = next_ptr_valid;
    if (next_ptr_valid) begin
      nda_next = {next_descriptor_pointer[31:2], 2'b00};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nda_reg <= 32'h0000_0000;
      ndv_reg <= 1'b0;
    end else begin
      nda_reg <= nda_next;
      ndv_reg <= ndv_next;
    end
  end

  // outputs; busy stalls the source while a word waits
  assign wb_valid = (wb_state_reg != HBSW_WB_IDLE);
  assign wb_req = wb_req_reg;
  assign tx_busy = tx_pend_reg;
  assign rx_busy = rx_pend_reg;
  assign tx_returned = tx_ret_reg;
  assign rx_returned = rx_ret_reg;
  assign rx_octet_write = oct_wr_reg;
  assign rx_octet_addr = oct_addr_reg;
  assign rx_octet_strb = oct_strb_reg;
  assign rx_discard = discard_reg;
  assign rx_hunt = hunt_reg;
  assign next_desc_addr = nda_reg;
  assign next_desc_valid = ndv_reg;

endmodule : hbsw_top

// ### hbsw_top_chk.sv
// hbsw_top_chk: port level checks of the status writeback block.
// assumes one pclk domain and a bench that never overlaps tx and rx words.
module hbsw_top_chk
  import hbsw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic tx_done,
  input wire logic tx_eom,
  input wire logic [13:0] tx_octets_sent,
  input wire logic [31:0] tx_desc_addr,
  input wire logic tx_busy,
  input wire logic tx_returned,
  input wire logic rx_busy,
  input wire logic rx_returned,
  input wire logic rx_octet_write,
  input wire logic [31:0] rx_octet_addr,
  input wire logic [3:0] rx_octet_strb,
  input wire logic [31:0] next_descriptor_pointer,
  input wire logic next_ptr_valid,
  input wire logic [31:0] next_desc_addr,
  input wire logic next_desc_valid,
  input wire logic wb_valid,
  input hbsw_pkg::hbsw_wb_req_s wb_req,
  input wire logic wb_ready
);
  import hbsw_pkg::*;
  // single domain, so one clock and one disable for all
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // tx done taken, word pending
  sequence s_tx_taken;
    tx_done ##1 tx_busy;
  endsequence
  // rx buffer closed, word pending
  sequence s_rx_taken;
    rx_returned && rx_busy;
  endsequence
  AST_TX_RET: assert property (tx_done |=> tx_returned)
    else $error("tx buffer not returned");
  AST_TX_WORD: assert property (s_tx_taken |-> ##1 wb_valid &&
    !wb_req.data[31] && wb_req.data[29] == $past(tx_eom, 2) &&
    wb_req.data[13:0] == $past(tx_octets_sent, 2) &&
    wb_req.addr == $past(tx_desc_addr, 2))
    else $error("tx status word wrong");
  AST_TX_RSVD: assert property (s_tx_taken |-> ##1
    wb_req.data[30] == 1'b0 && wb_req.data[28:14] == 15'h0000)
    else $error("tx reserved bits set");
  AST_RX_WORD: assert property (s_rx_taken |=> wb_valid &&
    wb_req.data[31] && !wb_req.data[30] && wb_req.data[28:20] == 9'h000
    && wb_req.data[15:14] == 2'h0)
    else $error("rx status word wrong");
  AST_RX_FAULT: assert property (wb_valid && wb_req.data[31] &&
    wb_req.data[19:16] != 4'h0 |-> wb_req.data[29] &&
    wb_req.data[19:16] inside {4'h1, 4'h2, [4'h8:4'hc]})
    else $error("rx fault code or end flag wrong");
  AST_NEXT_PTR: assert property (next_ptr_valid |=> next_desc_valid &&
    next_desc_addr == {$past(next_descriptor_pointer[31:2]), 2'b00})
    else $error("next descriptor address wrong");
  AST_LANE: assert property (rx_octet_write |->
    rx_octet_addr[1:0] == 2'b00 && $onehot(rx_octet_strb))
    else $error("octet lane wrong");
  AST_WB_HOLD: assert property (wb_valid && !wb_ready |=>
    wb_valid && $stable(wb_req))
    else $error("writeback dropped while stalled");
  AST_WB_DONE: assert property (wb_valid && wb_ready |=> !wb_valid)
    else $error("writeback repeated");
  AST_SLVERR: assert property (psel && penable && paddr > 8'h0c |->
    pslverr)
    else $error("unmapped access not refused");
endmodule : hbsw_top_chk

bind hbsw_top hbsw_top_chk u_hbsw_top_chk(.pclk, .presetn, .psel,
  .penable, .paddr, .pslverr, .tx_done, .tx_eom, .tx_octets_sent,
  .tx_desc_addr, .tx_busy, .tx_returned, .rx_busy, .rx_returned,
  .rx_octet_write, .rx_octet_addr, .rx_octet_strb,
  .next_descriptor_pointer, .next_ptr_valid, .next_desc_addr,
  .next_desc_valid, .wb_valid, .wb_req, .wb_ready);

// ### tb_hdlc_buffer_status_writeback.sv
// tb: apb, tx and rx status writeback, pointer forming.
// assumes hbsw_top, hbsw_host_mem and the bound checker are compiled.
module tb_hdlc_buffer_status_writeback
  import hbsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, oa;
  logic pready, pslverr, er, slow = 0;
  logic tx_active = 0, tx_done = 0, tx_eom = 0;
  logic [13:0] tx_octets_sent = 0, rx_buf_len = 14'h0100;
  logic [31:0] tx_desc_addr = 32'h2000_0040;
  logic [31:0] rx_desc_addr = 32'h3000_0080;
  logic [31:0] data_buffer_pointer = 32'h0000_1003;
  logic [31:0] next_descriptor_pointer = 0;
  logic rx_octet_valid = 0, rx_flag_end = 0, rx_abort_end = 0;
  logic rx_fcs_bad = 0, rx_fifo_overflow = 0, out_of_frame_input = 0;
  logic next_ptr_valid = 0, bit_tick = 0, receive_frame_sync = 0;
  logic [2:0] rx_residue_bits = 0;
  logic tx_busy, tx_returned, rx_busy, rx_returned, rx_octet_write;
  logic rx_discard, rx_hunt, next_desc_valid, wb_valid, wb_ready;
  logic [31:0] rx_octet_addr, next_desc_addr, last_addr, last_data;
  logic [3:0] rx_octet_strb, os;
  hbsw_wb_req_s wb_req;
  int writes, n0, fails = 0, comparisons = 0;
  hbsw_top u_hbsw_top(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_active, .tx_done, .tx_eom,
    .tx_octets_sent, .tx_desc_addr, .tx_busy, .tx_returned,
    .rx_desc_addr, .rx_buf_len, .data_buffer_pointer, .rx_octet_valid,
    .rx_flag_end, .rx_abort_end, .rx_fcs_bad, .rx_residue_bits,
    .rx_fifo_overflow, .bit_tick, .receive_frame_sync,
    .out_of_frame_input, .rx_busy, .rx_returned, .rx_octet_write,
    .rx_octet_addr, .rx_octet_strb, .rx_discard, .rx_hunt,
    .next_descriptor_pointer, .next_ptr_valid, .next_desc_addr,
    .next_desc_valid, .wb_valid, .wb_req, .wb_ready);
  hbsw_host_mem u_hbsw_host_mem(.pclk, .presetn, .slow, .wb_valid,
    .wb_req, .wb_ready, .last_addr, .last_data, .writes);
  always #2.5 pclk = ~pclk;
  // last octet lane written to memory
  always @(posedge pclk) begin
    if (rx_octet_write === 1'b1) begin
      oa <= rx_octet_addr;
      os <= rx_octet_strb;
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task complete_run;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // one apb transfer, held until pready sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  function logic [31:0] rxw(input logic eo, input logic [3:0] e,
                            input logic [13:0] n);
    return {1'b1, 1'b0, eo, 9'h000, e, 2'h0, n};
  endfunction : rxw
  task wait_wb;
    for (int i = 0; i < 80 && writes == n0; i++) @(posedge pclk);
    chk("word count", writes, n0 + 1);
  endtask : wait_wb
  // k: 0 none, 1 flag, 2 bad fcs, 3 bad fcs and residue, 4 abort, 5 ovf
  task rx_send(input int n, input int k);
    n0 = writes;
    @(posedge pclk);
    rx_octet_valid <= 1;
    repeat (n) @(posedge pclk);
    rx_octet_valid <= 0;
    rx_flag_end <= k inside {1, 2, 3};
    rx_fcs_bad <= k inside {2, 3};
    rx_residue_bits <= (k == 3) ? 3'h5 : 3'h0;
    rx_abort_end <= k == 4;
    rx_fifo_overflow <= k == 5;
    @(posedge pclk);
    {rx_flag_end, rx_fcs_bad, rx_abort_end, rx_fifo_overflow} <= 4'h0;
    rx_residue_bits <= 3'h0;
  endtask : rx_send
  task t_apb;
    apb(0, HBSW_LIMIT_OFS, 0);
    chk("limit reset", rd, 0);
    apb(1, HBSW_CTRL_OFS, 32'h3);
    apb(0, HBSW_CTRL_OFS, 0);
    chk("ctrl", rd, 32'h3);
    apb(1, HBSW_CTRL_OFS, 0);
    apb(0, 8'h10, 0);
    chk("unmapped err", er, 1);
    chk("unmapped data", rd, 0);
  endtask : t_apb
  task t_tx(input logic eo, input logic [13:0] ln, input logic sl);
    slow <= sl;
    tx_active <= 1;
    tx_eom <= eo;
    tx_octets_sent <= ln;
    apb(0, HBSW_TXSTAT_OFS, 0);
    chk("tx live owner", rd[31], 1);
    n0 = writes;
    @(posedge pclk);
    tx_active <= 0;
    tx_done <= 1;
    @(posedge pclk);
    tx_done <= 0;
    wait_wb();
    chk("tx addr", last_addr, tx_desc_addr);
    chk("tx word", last_data, {2'b00, eo, 15'h0, ln});
    slow <= 0;
  endtask : t_tx
  task t_rx;
    int ks[5] = '{1, 2, 3, 4, 5};
    logic [3:0] es[5] = '{4'h0, 4'h9, 4'ha, 4'hb, 4'h1};
    for (int i = 0; i < 5; i++) begin
      rx_send(3, ks[i]);
      wait_wb();
      chk("rx word", last_data, rxw(1, es[i], 3));
      chk("rx addr", last_addr, rx_desc_addr);
      chk("octet addr", oa, 32'h0000_1004);
      chk("octet lane", os, 4'b0010);
    end
    rx_buf_len <= 3;
    rx_send(3, 0);
    wait_wb();
    chk("full word", last_data, rxw(0, 0, 3));
    rx_buf_len <= 14'h0100;
    n0 = writes;
    out_of_frame_input <= 1;
    wait_wb();
    chk("oof word", last_data, rxw(1, 4'h8, 0));
    out_of_frame_input <= 0;
    n0 = writes;
    bit_tick <= 1;
    repeat (10) @(posedge pclk);
    receive_frame_sync <= 1;
    wait_wb();
    chk("frame_alignment_change", last_data, rxw(1, 2, 0));
    apb(1, HBSW_LIMIT_OFS, 2);
    rx_send(3, 1);
    wait_wb();
    chk("long word", last_data, rxw(1, 4'hc, 2));
    chk("long lane", os, 1);
    repeat (10) @(posedge pclk);
    chk("long one word", writes, n0 + 1);
    apb(1, HBSW_LIMIT_OFS, 0);
  endtask : t_rx
  task t_ptr;
    @(posedge pclk);
    next_descriptor_pointer <= 32'h3000_0083;
    next_ptr_valid <= 1;
    @(posedge pclk);
    next_ptr_valid <= 0;
    #1;
    chk("next valid", next_desc_valid, 1);
    chk("next addr", next_desc_addr, 32'h3000_0080);
  endtask : t_ptr
  task t_inh;
    apb(1, HBSW_CTRL_OFS, 32'h3);
    n0 = writes;
    @(posedge pclk);
    tx_done <= 1;
    @(posedge pclk);
    tx_done <= 0;
    repeat (10) @(posedge pclk);
    rx_send(2, 1);
    repeat (10) @(posedge pclk);
    chk("inhibit writes", writes, n0);
    apb(1, HBSW_CTRL_OFS, 0);
  endtask : t_inh
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_apb();
    t_tx(1, 14'h3fff, 0);
    t_tx(0, 14'h0001, 1);
    t_rx();
    t_ptr();
    t_inh();
    complete_run();
  end
  // hang guard
  initial begin
    #100000;
    fails++;
    complete_run();
  end
endmodule : tb_hdlc_buffer_status_writeback
